// ---- ecsc_pkg.sv ----
// constants shared by the chip select configuration block
`default_nettype none
package ecsc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned  ADDR_W       = 5;
  localparam logic [4:0]   OFS_CS1_BASE = 5'h00;
  localparam logic [4:0]   OFS_CS2_BASE = 5'h04;
  localparam logic [4:0]   OFS_CS1_MODE = 5'h08;
  localparam logic [4:0]   OFS_CS2_MODE = 5'h0C;
  localparam logic [4:0]   OFS_STATUS   = 5'h10;
  localparam logic [15:0]  BASE_MASK    = 16'hFF88;
  localparam logic [15:0]  MODE_MASK    = 16'hF8FF;
  localparam logic [15:0]  CS1_BASE_RST = 16'h0200;
  localparam logic [15:0]  CS2_BASE_RST = 16'h0600;
  localparam logic [15:0]  MODE_RST     = 16'h0000;
  localparam logic [1:0]   RESP_OKAY    = 2'b00;
  localparam logic [1:0]   RESP_SLVERR  = 2'b10;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned  BASE_HI_MSB  = 15;
  localparam int unsigned  BASE_HI_LSB  = 7;
  localparam int unsigned  BASE_LO_BIT  = 3;
  localparam int unsigned  ACKM_LSB     = 14;
  localparam int unsigned  AMW_LSB      = 11;
  localparam int unsigned  DWB_LSB      = 6;
  localparam int unsigned  DWM_LSB      = 2;
  localparam int unsigned  DWE_LSB      = 0;
  localparam int unsigned  ST_BUSY      = 0;
  localparam int unsigned  ST_ZERO_EXT  = 1;
  localparam int unsigned  ST_TIMEOUT   = 2;
  // ****************************************************************
  // timing, counted in quarter instruction cycles (one mclk each)
  // ****************************************************************
  localparam logic [1:0]   ACK_OFF      = 2'b00;
  localparam logic [1:0]   ACK_RSVD     = 2'b11;
  localparam logic [9:0]   QTR_PER_TCY  = 10'd4;
  localparam logic [9:0]   SETUP_BIAS   = 10'd1;
  localparam logic [9:0]   WR_STB_BIAS  = 10'd2;
  localparam logic [9:0]   RD_STB_BIAS  = 10'd3;
  localparam logic [9:0]   HOLD_BIAS    = 10'd1;
  localparam logic [9:0]   AMW_BIAS     = 10'd3;
  localparam logic [9:0]   ACK_MAX_Q    = 10'd1020;
endpackage
`default_nettype wire

// ---- ecsc_decode.sv ----
// address window decode for the two chip selects
`default_nettype none
module ecsc_decode
  import ecsc_pkg::*;
(
  input  wire logic [15:0] base1_i,
  input  wire logic [15:0] base2_i,
  input  wire logic        zero_ext_i,
  input  wire logic [23:0] addr_i,
  output logic      [1:0]  hit_o
);
  logic [23:0] start1;
  logic [23:0] start2;
  // ****************************************************************
  // window starts from packed base fields
  // ****************************************************************
  always_comb begin
    start1 = '0;
    start2 = '0;
    start1[23:15] = base1_i[BASE_HI_MSB:BASE_HI_LSB]; // R1
    start1[11]    = base1_i[BASE_LO_BIT]; // R1
    start2[23:15] = base2_i[BASE_HI_MSB:BASE_HI_LSB]; // R1
    start2[11]    = base2_i[BASE_LO_BIT]; // R1
    hit_o[0] = (addr_i >= start1) && (zero_ext_i || addr_i < start2); // R4
    hit_o[1] = !zero_ext_i && (addr_i >= start2); // R4
  end
endmodule
`default_nettype wire

// ---- ecsc_seq.sv ----
// access strobe sequencer and alternate master wait
`default_nettype none
module ecsc_seq
  import ecsc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        we_i,
  input  wire logic [1:0]  cs_i,
  input  wire logic [15:0] mode_i,
  input  wire logic        ack_i,
  input  wire logic        alt_req_i,
  input  wire logic [2:0]  alt_wait_i,
  output logic             busy_o,
  output logic             strobe_o,
  output logic [1:0]       cs_o,
  output logic             data_oe_o,
  output logic             done_o,
  output logic             timeout_o,
  output logic             alt_grant_o
);
  typedef enum logic [2:0] {
    S_IDLE, S_ALT, S_GRANT, S_SETUP, S_STB, S_HOLD
  } ecsc_st_e;
  typedef struct packed {
    ecsc_st_e   st;
    logic [9:0] cnt;
    logic       we;
    logic [1:0] ackm;
    logic [3:0] dwm;
    logic [1:0] dwe;
    logic       busy;
    logic       strobe;
    logic [1:0] cs;
    logic       oe;
    logic       done;
    logic       tmo;
    logic       grant;
  } ecsc_seq_s;
  ecsc_seq_s s_r;
  ecsc_seq_s s_nxt;
  logic      ack_used;
  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    ack_used   = (s_r.ackm != ACK_OFF) && (s_r.ackm != ACK_RSVD); // R7
    case (s_r.st)
      S_IDLE: begin
        if (start_i) begin
          s_nxt.st   = S_SETUP;
          s_nxt.we   = we_i;
          s_nxt.ackm = mode_i[ACKM_LSB +: 2];
          s_nxt.dwm  = mode_i[DWM_LSB +: 4];
          s_nxt.dwe  = mode_i[DWE_LSB +: 2];
          s_nxt.cnt  = {6'd0, mode_i[DWB_LSB +: 2], 2'd0}
                       + SETUP_BIAS - 10'd1; // R8
          s_nxt.busy = 1'b1;
          s_nxt.cs   = cs_i;
          s_nxt.oe   = we_i;
        end else if (alt_req_i) begin
          s_nxt.st  = S_ALT;
          s_nxt.cnt = {7'd0, alt_wait_i} + AMW_BIAS - 10'd1; // R6
        end
      end
      S_ALT: begin
        if (!alt_req_i) begin
          s_nxt.st = S_IDLE;
        end else if (s_r.cnt == 10'd0) begin
          s_nxt.st    = S_GRANT; // R6
          s_nxt.grant = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 10'd1;
        end
      end
      S_GRANT: begin
        if (!alt_req_i) begin
          s_nxt.st    = S_IDLE;
          s_nxt.grant = 1'b0;
        end
      end
      S_SETUP: begin
        if (s_r.cnt == 10'd0) begin
          s_nxt.st     = S_STB;
          s_nxt.strobe = 1'b1;
          if (ack_used) begin
            s_nxt.cnt = ACK_MAX_Q - 10'd1; // R7
          end else begin
            s_nxt.cnt = {4'd0, s_r.dwm, 2'd0} - 10'd1
                        + (s_r.we ? WR_STB_BIAS : RD_STB_BIAS); // R9
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 10'd1;
        end
      end
      S_STB: begin
        if ((ack_used && ack_i) || s_r.cnt == 10'd0) begin // R7
          s_nxt.st     = S_HOLD;
          s_nxt.strobe = 1'b0;
          s_nxt.tmo    = ack_used && !ack_i;
          s_nxt.cnt    = {6'd0, s_r.dwe, 2'd0} + HOLD_BIAS - 10'd1; // R10
        end else begin
          s_nxt.cnt = s_r.cnt - 10'd1;
        end
      end
      S_HOLD: begin
        if (s_r.cnt == 10'd0) begin
          s_nxt.st   = S_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.cs   = 2'b00;
          s_nxt.oe   = 1'b0;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 10'd1;
        end
      end
      default: begin
        s_nxt = '0;
      end
    endcase
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign busy_o      = s_r.busy;
  assign strobe_o    = s_r.strobe;
  assign cs_o        = s_r.cs;
  assign data_oe_o   = s_r.oe;
  assign done_o      = s_r.done;
  assign timeout_o   = s_r.tmo;
  assign alt_grant_o = s_r.grant;
  // ****************************************************************
  // checks
  // ****************************************************************
  sequence q_setup13;
    (!strobe_o)[*8] ##1 (!strobe_o)[*5] ##1 strobe_o;
  endsequence
  sequence q_hold13;
    (!done_o)[*8] ##1 (!done_o)[*5] ##1 done_o;
  endsequence
  a_setup_three_q: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
    (s_r.st == S_IDLE && start_i && mode_i[DWB_LSB +: 2] == 2'b11)
    |=> q_setup13)
    else $error("setup wait for code 11 is not 13 cycles");
  a_strobe_half_w: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
    ($rose(strobe_o) && s_r.we && s_r.dwm == 4'd0 && !ack_used)
    |-> ##1 strobe_o ##1 !strobe_o)
    else $error("write strobe for code 0000 is not 2 cycles");
  a_strobe_max_w: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
    ($rose(strobe_o) && s_r.we && s_r.dwm == 4'hF && !ack_used)
    |-> ##61 strobe_o ##1 !strobe_o)
    else $error("write strobe for code 1111 is not 62 cycles");
  a_hold_three_q: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
    ($fell(strobe_o) && s_r.we && s_r.dwe == 2'b11) |-> q_hold13)
    else $error("write hold for code 11 is not 13 cycles");
  a_alt_wait_ten: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
    (s_r.st == S_IDLE && !start_i && alt_req_i && alt_wait_i == 3'b111)
    ##1 alt_req_i[*8] ##1 alt_req_i[*2] |=> alt_grant_o)
    else $error("alternate master wait for 111 is not 10 cycles");
  a_alt_not_early: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
    (s_r.st == S_IDLE && !start_i && alt_req_i && alt_wait_i == 3'b111)
    |=> (!alt_grant_o)[*8] ##1 !alt_grant_o)
    else $error("alternate master granted early");
  a_ack_ignored: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
    (s_r.st == S_STB && s_r.ackm == ACK_OFF && ack_i && s_r.cnt != 10'd0)
    |=> strobe_o)
    else $error("acknowledge ended strobe while ignored");
  a_ack_ends_stb: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
    (s_r.st == S_STB && ack_used && ack_i) |=> !strobe_o ##1 !strobe_o)
    else $error("acknowledge did not end strobe");
endmodule
`default_nettype wire

// ---- ecsc_top.sv ----
// chip select window and timing configuration with axi4-lite registers
//
// Functional notes
// R1: base register bits 15..7 hold address bits 23..15, bit 3 holds bit 11.
// R2: base register bits 6..4 and 2..0 are not stored and read as zero.
// R3: after reset chip select 1 base is 0x0200 and chip select 2 is 0x0600.
// R4: a whole zero write to chip select 2 base stretches window 1 to the top.
// R5: a zero write to chip select 1 base stretches nothing.
// R6: alternate master wait code 111 waits ten alternate master cycles.
// R7: ack mode 00 ignores the acknowledge, 01 and 10 use it, 11 is reserved.
// R8: data setup code 11 gives three and a quarter instruction cycles.
// R9: write strobe wait is the code plus one half instruction cycle.
// R10: write data hold code 11 gives three and a quarter instruction cycles.
`default_nettype none
module ecsc_top
  import ecsc_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              acc_req_i,
  input  wire logic              acc_we_i,
  input  wire logic [23:0]       acc_addr_i,
  input  wire logic              ext_ack_input_i,
  input  wire logic              alt_req_i,
  output logic                   acc_busy_o,
  output logic                   acc_done_o,
  output logic                   strobe_o,
  output logic [1:0]             cs_sel_o,
  output logic                   data_oe_o,
  output logic                   alt_grant_o
);
  typedef struct packed {
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [15:0]       base1;
    logic [15:0]       base2;
    logic [15:0]       mode1;
    logic [15:0]       mode2;
    logic              zero_ext;
    logic              tmo;
    logic [1:0]        ack_s;
    logic              start;
    logic              we;
    logic [1:0]        cs;
  } ecsc_top_s;
  ecsc_top_s r_r;
  ecsc_top_s r_nxt;
  logic [1:0]  hit;
  logic        seq_busy;
  logic        seq_tmo;
  logic        seq_done;
  logic        wr_fire;
  logic        rd_fire;
  logic        acc_take;
  logic [15:0] wr_val;
  logic [15:0] old_val;
  logic [15:0] rd_val;
  // ****************************************************************
  // submodules
  // ****************************************************************
  ecsc_decode u_decode (
    .base1_i    (r_r.base1),
    .base2_i    (r_r.base2),
    .zero_ext_i (r_r.zero_ext),
    .addr_i     (acc_addr_i),
    .hit_o      (hit)
  );
  ecsc_seq u_seq (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .start_i     (r_r.start),
    .we_i        (r_r.we),
    .cs_i        (r_r.cs),
    .mode_i      (r_r.cs[1] ? r_r.mode2 : r_r.mode1),
    .ack_i       (r_r.ack_s[1]),
    .alt_req_i   (alt_req_i),
    .alt_wait_i  (r_r.mode1[AMW_LSB +: 3]),
    .busy_o      (seq_busy),
    .strobe_o    (strobe_o),
    .cs_o        (cs_sel_o),
    .data_oe_o   (data_oe_o),
    .done_o      (seq_done),
    .timeout_o   (seq_tmo),
    .alt_grant_o (alt_grant_o)
  );
  // ****************************************************************
  // register bus and access capture
  // ****************************************************************
  always_comb begin
    r_nxt       = r_r;
    r_nxt.start = 1'b0;
    r_nxt.ack_s = {r_r.ack_s[0], ext_ack_input_i};
    if (seq_done) begin
      r_nxt.tmo = seq_tmo;
    end
    // byte merge for the write under way
    case (r_r.waddr)
      OFS_CS1_BASE: old_val = r_r.base1;
      OFS_CS2_BASE: old_val = r_r.base2;
      OFS_CS1_MODE: old_val = r_r.mode1;
      OFS_CS2_MODE: old_val = r_r.mode2;
      default:      old_val = 16'h0000;
    endcase
    wr_val[7:0]  = r_r.wstrb[0] ? r_r.wdata[7:0] : old_val[7:0];
    wr_val[15:8] = r_r.wstrb[1] ? r_r.wdata[15:8] : old_val[15:8];
    if (s_axi_awvalid && !r_r.aw_got) begin
      r_nxt.aw_got = 1'b1;
      r_nxt.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_r.w_got) begin
      r_nxt.w_got = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end
    wr_fire = r_r.aw_got && r_r.w_got && !r_r.bvalid;
    if (wr_fire) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got  = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = RESP_OKAY;
      case (r_r.waddr)
        OFS_CS1_BASE: r_nxt.base1 = wr_val & BASE_MASK; // R2 R5
        OFS_CS2_BASE: begin
          r_nxt.base2    = wr_val & BASE_MASK; // R2
          r_nxt.zero_ext = (r_r.wstrb[1:0] == 2'b11)
                           && (r_r.wdata[15:0] == 16'h0000); // R4
        end
        OFS_CS1_MODE: r_nxt.mode1 = wr_val & MODE_MASK;
        OFS_CS2_MODE: r_nxt.mode2 = wr_val & MODE_MASK;
        OFS_STATUS:   r_nxt.bresp = RESP_OKAY;
        default:      r_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    rd_fire = s_axi_arvalid && !r_r.rvalid;
    rd_val  = 16'h0000;
    case (s_axi_araddr)
      OFS_CS1_BASE: rd_val = r_r.base1;
      OFS_CS2_BASE: rd_val = r_r.base2;
      OFS_CS1_MODE: rd_val = r_r.mode1;
      OFS_CS2_MODE: rd_val = r_r.mode2;
      default: begin
        rd_val[ST_BUSY]     = seq_busy || r_r.start;
        rd_val[ST_ZERO_EXT] = r_r.zero_ext;
        rd_val[ST_TIMEOUT]  = r_r.tmo;
      end
    endcase
    if (rd_fire) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata  = {16'h0000, rd_val};
      r_nxt.rresp  = (s_axi_araddr > OFS_STATUS
                      || s_axi_araddr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
    end else if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    // external access request
    acc_take = acc_req_i && !seq_busy && !r_r.start;
    if (acc_take) begin
      r_nxt.start = 1'b1;
      r_nxt.we    = acc_we_i;
      r_nxt.cs    = hit; // R4 R5
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      r_r       <= '0;
      r_r.base1 <= CS1_BASE_RST; // R3
      r_r.base2 <= CS2_BASE_RST; // R3
      r_r.mode1 <= MODE_RST;
      r_r.mode2 <= MODE_RST;
    end else begin
      r_r <= r_nxt;
    end
  end
  assign s_axi_awready = !r_r.aw_got;
  assign s_axi_wready  = !r_r.w_got;
  assign s_axi_bvalid  = r_r.bvalid;
  assign s_axi_bresp   = r_r.bresp;
  assign s_axi_arready = !r_r.rvalid;
  assign s_axi_rvalid  = r_r.rvalid;
  assign s_axi_rdata   = r_r.rdata;
  assign s_axi_rresp   = r_r.rresp;
  assign acc_busy_o    = seq_busy;
  assign acc_done_o    = seq_done;
  // ****************************************************************
  // checks
  // ****************************************************************
  a_base_reset_val: assert property (@(posedge mclk_i) // R3
    $fell(rst_i) |-> r_r.base1 == CS1_BASE_RST && r_r.base2 == CS2_BASE_RST)
    else $error("base registers left reset with wrong values");
  a_unimpl_read_zero: assert property (@(posedge mclk_i) // R2
    disable iff (rst_i)
    (!r_r.rvalid || r_r.rdata[31:16] == 16'h0000)
    && (((r_r.base1 | r_r.base2) & ~BASE_MASK) == 16'h0000))
    else $error("unimplemented base bits not zero");
  a_base_field_wr: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
    (wr_fire && r_r.waddr == OFS_CS1_BASE && r_r.wstrb[1:0] == 2'b11)
    |=> r_r.base1 == ($past(r_r.wdata[15:0]) & BASE_MASK))
    else $error("base field not stored from write data");
  a_cs2_zero_ext: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
    (acc_take && r_r.zero_ext
     && acc_addr_i[23:15] > r_r.base1[BASE_HI_MSB:BASE_HI_LSB])
    |=> r_r.cs == 2'b01)
    else $error("zero write did not stretch window one");
  a_cs1_no_ext: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
    (wr_fire && r_r.waddr == OFS_CS1_BASE)
    |=> r_r.zero_ext == $past(r_r.zero_ext))
    else $error("write to base one changed window stretch");
endmodule
`default_nettype wire

// ---- ecsc_ext_dev.sv ----
// external device model that acknowledges strobed accesses
`default_nettype none
module ecsc_ext_dev (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       strobe_i,
  input  wire logic [1:0] cs_sel_i,
  input  wire logic [7:0] dly_i,
  output logic            ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  // acknowledge a selected strobe dly_i + 1 cycles after it rises, low otherwise
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 8'h00;
      ack_o <= 1'b0;
    end else if (strobe_i && cs_sel_i != 2'b00) begin
      cnt_r <= cnt_r + 8'h01;
      ack_o <= (cnt_r >= dly_i);
    end else begin
      cnt_r <= 8'h00;
      ack_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- ecsc_top_tb.sv ----
// self-checking bench for the chip select configuration block
`default_nettype none
module ecsc_top_tb
  import ecsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals and instances
  // ****
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, cs_sel;
  logic [31:0] rdata;
  logic        acc_req = 1'b0, acc_we = 1'b0, alt_req = 1'b0;
  logic [23:0] acc_addr = 24'h00_0000;
  logic        ack, busy, done, strobe, oe, grant;
  logic [7:0]  dly = 8'h02;
  logic [15:0] rd;
  logic [1:0]  cs;
  logic        oe_seen;
  int          bad_count = 0, checks_done = 0, cyc = 0;
  int          s, w, h, n;

  ecsc_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .acc_req_i(acc_req),
    .acc_we_i(acc_we), .acc_addr_i(acc_addr), .ext_ack_input_i(ack),
    .alt_req_i(alt_req), .acc_busy_o(busy), .acc_done_o(done),
    .strobe_o(strobe), .cs_sel_o(cs_sel), .data_oe_o(oe),
    .alt_grant_o(grant));
  ecsc_ext_dev u_dev (.mclk_i(mclk_i), .rst_i(rst_i), .strobe_i(strobe),
    .cs_sel_i(cs_sel), .dly_i(dly), .ack_o(ack));

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  // ****
  // tasks
  // ****
  task automatic summarize();
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [15:0] d,
                     input logic [1:0] er);
    logic aw, wd;
    aw = 1'b1;
    wd = 1'b1;
    @(posedge mclk_i);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (bvalid === 1'b1) chk(bresp, er, "write response");
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (wd && wready === 1'b1) begin
        wd = 1'b0;
        wvalid <= 1'b0;
      end
    end while (aw || wd || bvalid !== 1'b1);
  endtask
  task automatic axr(input logic [4:0] a, output logic [15:0] d,
                     output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    @(posedge mclk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      d = rdata[15:0];
      r = rresp;
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end while (ar || rvalid !== 1'b1);
  endtask
  task automatic acc(input logic we, input logic [23:0] a);
    @(posedge mclk_i);
    acc_we   <= we;
    acc_addr <= a;
    acc_req  <= 1'b1;
    @(posedge mclk_i);
    acc_req <= 1'b0;
    s = 0;
    w = 0;
    h = 0;
    cs = 2'b00;
    oe_seen = 1'b0;
    do begin
      @(negedge mclk_i);
      if (strobe === 1'b1) begin
        w++;
        cs = cs_sel;
        oe_seen = oe;
      end else if (w == 0 && busy === 1'b1) s++;
      else if (w > 0 && done !== 1'b1) h++;
    end while (done !== 1'b1);
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    axr(OFS_CS1_BASE, rd, cs);
    chk(rd, CS1_BASE_RST, "cs1 base reset");
    axr(OFS_CS2_BASE, rd, cs);
    chk(rd, CS2_BASE_RST, "cs2 base reset");
    axw(OFS_CS1_BASE, 16'hFFFF, RESP_OKAY);
    axr(OFS_CS1_BASE, rd, cs);
    chk(rd, 16'hFF88, "base unimplemented bits");
    axw(OFS_CS1_BASE, 16'h0208, RESP_OKAY);
    acc(1'b1, 24'h02_0400);
    chk(cs, 2'b00, "below window one");
    acc(1'b1, 24'h02_0800);
    chk(cs, 2'b01, "window one start");
    acc(1'b1, 24'hFF_FFF0);
    chk(cs, 2'b10, "window two");
    chk(s, 1, "short write setup");
    chk(w, 2, "short write strobe");
    chk(h, 1, "short write hold");
    chk(oe_seen, 1'b1, "write data not driven");
    axw(OFS_CS2_BASE, 16'h0000, RESP_OKAY);
    axr(OFS_STATUS, rd, cs);
    chk(rd[ST_ZERO_EXT], 1'b1, "zero extend flag");
    acc(1'b1, 24'hFF_FFF0);
    chk(cs, 2'b01, "window one to top");
    axw(OFS_CS2_BASE, 16'h0600, RESP_OKAY);
    axw(OFS_CS1_BASE, 16'h0000, RESP_OKAY);
    axr(OFS_STATUS, rd, cs);
    chk(rd[ST_ZERO_EXT], 1'b0, "cs1 zero write");
    acc(1'b1, 24'hFF_FFF0);
    chk(cs, 2'b10, "no extension from cs1");
    axw(OFS_CS1_BASE, 16'h0200, RESP_OKAY);
    axw(OFS_CS1_MODE, 16'h00FF, RESP_OKAY);
    acc(1'b1, 24'h03_0000);
    chk(s, 13, "long write setup");
    chk(w, 62, "long write strobe");
    chk(h, 13, "long write hold");
    acc(1'b0, 24'h03_0000);
    chk(w, 63, "long read strobe");
    chk(oe_seen, 1'b0, "read data driven");
    for (int k = 0; k < 3; k++) begin
      dly <= 8'(2 + 5 * k);
      axw(OFS_CS1_MODE, {2'(k), 14'h00FF}, RESP_OKAY);
      acc(1'b1, 24'h03_0000);
      if (k == 0) chk(w, 62, "ack ignored");
      else chk(w > 2 + 5 * k && w < 10 + 5 * k, 1, "ack used");
    end
    axw(OFS_CS1_MODE, 16'h3800, RESP_OKAY);
    @(posedge mclk_i);
    alt_req <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (grant !== 1'b1 && n < 40);
    chk(n >= 10 && n <= 12, 1, "alternate master wait");
    @(posedge mclk_i);
    alt_req <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(grant, 1'b0, "grant release");
    axr(5'h14, rd, cs);
    chk(cs, RESP_SLVERR, "unmapped read");
    axw(5'h18, 16'h1234, RESP_SLVERR);
    axw(OFS_CS2_MODE, 16'hFFFF, RESP_OKAY);
    axr(OFS_CS2_MODE, rd, cs);
    chk(rd, MODE_MASK, "mode unimplemented bits");
    summarize();
  end
endmodule
`default_nettype wire
